// >>> logic/adc_result_registers.sv
// Purpose: Read-only bank of converter results read byte by byte.
// Assumes: Converter, sequencer and disable controls share sys_clk_in.
// Notes:   A high-byte read freezes the word for a matching low-byte read that comes next.
//          Converter codes outside a channel's span saturate at its ends.
//
// Operation
// RQ1: Input source results: signed, 0 to 30 V.
// RQ2: Millivolt results: one mV per code, no offset.
// RQ3: Battery result is positive minus negative sense.
// RQ4: System rail result: signed mV, 0 to 24 V.
// RQ5: Thermistor ratio unsigned, max code 99.9023 percent.
// RQ6: Die temperature signed half degrees, -40 to 150.
// RQ7: D+ result unsigned mV, 0 to 3600.
// RQ8: Disabled channel is not converted or updated.
// RQ9: Both bytes of one read match one result.
`timescale 1ns/1ps
`default_nettype none
module adc_result_registers
    import adc_result_pkg::*;
#(
    parameter int CHANNELS = CHANNEL_COUNT
) (
    input  wire logic        sys_clk_in,          // 10 MHz register clock
    input  wire logic        rst_b_in,            // Sync reset, active low
    input  wire logic        conv_valid_in,       // One-cycle result strobe
    input  wire logic [2:0]  conv_channel_in,     // Channel of this result
    input  wire logic [15:0] conv_code_in,        // Raw code; two's complement except ratio and D+ (unsigned)
    input  wire logic [15:0] battery_sense_positive_in, // Positive sense code, mV
    input  wire logic [15:0] battery_sense_negative_in, // Negative sense code, mV
    input  wire logic [6:0]  channel_disable_in,  // Per channel, 1 = off
    input  wire logic        rd_en_in,            // One-cycle byte read
    input  wire logic [7:0]  rd_addr_in,          // Byte address
    output logic [6:0]       conv_request_out,    // Channels allowed to convert
    output logic [7:0]       rd_data_out,         // Read byte
    output logic             rd_valid_out         // Read byte ready
);

    logic [15:0]        result [CHANNELS];
    logic [15:0]        frozen_word;
    logic [7:0]         frozen_addr;
    logic               frozen_ok;
    logic signed [16:0] battery_diff;
    logic signed [16:0] next_code;
    logic signed [16:0] span_code;
    logic signed [16:0] span_lo;
    logic signed [16:0] span_hi;
    logic [15:0]        limited_code;
    logic               store_en;
    logic               read_mapped;
    logic               read_high;
    logic               read_frozen_low;
    logic [2:0]         read_channel;

    // Clamp a signed code into the channel's documented span
    function automatic logic [15:0] clamp_code(input logic signed [16:0] code,
                                               input logic signed [16:0] lo,
                                               input logic signed [16:0] hi);
        logic signed [16:0] v;
        v = code;
        if (v < lo) begin
            v = lo;
        end
        if (v > hi) begin
            v = hi;
        end
        return v[15:0];
    endfunction : clamp_code

    // Map a byte address to its channel; high byte sits at the odd address
    function automatic logic [2:0] addr_channel(input logic [7:0] addr);
        logic [7:0] off;
        off = addr - RESULT_FIRST_ADDR;
        return off[3:1];
    endfunction : addr_channel

    // Result window check, shared by the freeze and read paths
    function automatic logic addr_mapped(input logic [7:0] addr);
        return (addr >= RESULT_FIRST_ADDR) && (addr <= RESULT_LAST_ADDR);
    endfunction : addr_mapped

    // Widen a two's complement code by its sign bit
    function automatic logic signed [16:0] sign_widen(input logic [15:0] code);
        return {code[15], code};
    endfunction : sign_widen

    // Widen an unsigned code with a zero top bit
    function automatic logic signed [16:0] zero_widen(input logic [15:0] code);
        return {1'b0, code};
    endfunction : zero_widen

    assign conv_request_out = ~channel_disable_in; // RQ8

    // Battery result formed from the two sense codes; even a full-scale
    // difference fits the widened code, so nothing wraps before the clamp
    always_comb begin
        battery_diff = sign_widen(battery_sense_positive_in)
                     - sign_widen(battery_sense_negative_in); // RQ3
    end

    always_comb begin
        next_code = sign_widen(conv_code_in);
        if (conv_channel_in == CH_BATTERY) begin
            next_code = battery_diff; // RQ3
        end
    end

    // Channel 7 and disabled channels are dropped with no indication;
    // the old word simply stands
    always_comb begin
        store_en = 1'b0;
        if (conv_valid_in && (int'(conv_channel_in) < CHANNELS)) begin
            store_en = !channel_disable_in[conv_channel_in]; // RQ8
        end
    end

    // Span of each channel; unsigned channels widen with a zero top bit
    always_comb begin
        span_code = next_code;
        span_lo   = ZERO_CODE;
        span_hi   = ZERO_CODE;
        case (conv_channel_in)
            CH_INPUT1, CH_INPUT2: begin
                span_hi = INPUT_MAX_CODE; // RQ1 RQ2
            end
            CH_BATTERY: begin
                span_hi = BATTERY_MAX_CODE; // RQ3
            end
            CH_SYSTEM: begin
                span_hi = SYSTEM_MAX_CODE; // RQ4
            end
            CH_THERM: begin
                span_code = zero_widen(conv_code_in);
                span_hi   = THERM_MAX_CODE; // RQ5
            end
            CH_DIE: begin
                span_lo = DIE_MIN_CODE; // RQ6
                span_hi = DIE_MAX_CODE; // RQ6
            end
            CH_DPLUS: begin
                span_code = zero_widen(conv_code_in);
                span_hi   = DPLUS_MAX_CODE; // RQ7
            end
            default: begin
                span_hi = ZERO_CODE;
            end
        endcase
    end

    // Out-of-span codes saturate rather than wrap
    assign limited_code = clamp_code(span_code, span_lo, span_hi);

    // Result storage
    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            for (int i = 0; i < CHANNELS; i++) begin
                result[i] <= RESULT_RESET; // RQ1 RQ7
            end
        end else if (store_en) begin
            result[conv_channel_in] <= limited_code; // RQ8
        end
    end

    // Read decode shared by the freeze and data paths
    always_comb begin
        read_mapped     = addr_mapped(rd_addr_in);
        read_high       = read_mapped && rd_addr_in[0];
        read_frozen_low = read_mapped && !rd_addr_in[0] && frozen_ok
                          && (frozen_addr == rd_addr_in); // RQ9
        read_channel    = addr_channel(rd_addr_in);
    end

    // Word frozen on the high-byte read so a result landing between the
    // two byte reads cannot tear the pair
    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            frozen_word <= RESULT_RESET;
            frozen_addr <= 8'h00;
        end else if (rd_en_in && read_high) begin
            frozen_word <= result[read_channel]; // RQ9
            frozen_addr <= rd_addr_in + 8'h01;
        end
    end

    // Any other read, the matching low byte included, ends the pairing
    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            frozen_ok <= 1'b0;
        end else if (rd_en_in) begin
            frozen_ok <= read_high; // RQ9
        end
    end

    // Every read is answered one cycle later, mapped or not, so the
    // host side never has to time out
    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            rd_valid_out <= 1'b0;
        end else begin
            rd_valid_out <= rd_en_in;
        end
    end

    // Read byte holds until the next read
    always_ff @(posedge sys_clk_in) begin
        if (!rst_b_in) begin
            rd_data_out <= UNMAPPED_READ;
        end else if (rd_en_in) begin
            if (!read_mapped) begin
                rd_data_out <= UNMAPPED_READ;
            end else if (read_high) begin
                rd_data_out <= result[read_channel][15:8];
            end else if (read_frozen_low) begin
                rd_data_out <= frozen_word[7:0]; // RQ9
            end else begin
                // Lone low-byte read gives the live value
                rd_data_out <= result[read_channel][7:0];
            end
        end
    end

endmodule : adc_result_registers
`default_nettype wire

// >>> shared/adc_result_pkg.sv
// Purpose: Constants shared by the converter result bank.
// Assumes: Byte-wide register reads, high byte at the printed offset.
// Notes:   Codes are millivolts, 0.5 degC steps or ratio steps, zero offset.
package adc_result_pkg;

    localparam int          CHANNEL_COUNT = 7;
    localparam int          CODE_WIDTH    = 16;

    // Channel numbers as presented by the converter sequencer
    typedef enum logic [2:0] {
        CH_INPUT1  = 3'h0,
        CH_INPUT2  = 3'h1,
        CH_BATTERY = 3'h2,
        CH_SYSTEM  = 3'h3,
        CH_THERM   = 3'h4,
        CH_DIE     = 3'h5,
        CH_DPLUS   = 3'h6
    } channel_e;

    // Byte address of each result's high byte; the low byte follows
    localparam logic [7:0] INPUT1_VOLTAGE_RESULT_ADDR     = 8'h37;
    localparam logic [7:0] INPUT2_VOLTAGE_RESULT_ADDR     = 8'h39;
    localparam logic [7:0] BATTERY_VOLTAGE_RESULT_ADDR    = 8'h3B;
    localparam logic [7:0] SYSTEM_VOLTAGE_RESULT_ADDR     = 8'h3D;
    localparam logic [7:0] THERMISTOR_RATIO_RESULT_ADDR   = 8'h3F;
    localparam logic [7:0] DIE_TEMPERATURE_RESULT_ADDR    = 8'h41;
    localparam logic [7:0] USB_DPLUS_VOLTAGE_RESULT_ADDR  = 8'h43;
    localparam logic [7:0] RESULT_FIRST_ADDR              = 8'h37;
    localparam logic [7:0] RESULT_LAST_ADDR               = 8'h44;

    localparam logic [15:0] RESULT_RESET = 16'h0000;
    localparam logic [7:0]  UNMAPPED_READ = 8'h00;

    // Range limits in codes (1 mV, 0.5 degC, 0.0976563 % per code)
    localparam logic signed [16:0] INPUT_MAX_CODE   = 17'sh07530; // 30000 mV
    localparam logic signed [16:0] BATTERY_MAX_CODE = 17'sh04E20; // 20000 mV
    localparam logic signed [16:0] SYSTEM_MAX_CODE  = 17'sh05DC0; // 24000 mV
    localparam logic signed [16:0] THERM_MAX_CODE   = 17'sh003FF; // 99.9023 %
    localparam logic signed [16:0] DIE_MIN_CODE     = -17'sh00050; // -40 degC
    localparam logic signed [16:0] DIE_MAX_CODE     = 17'sh0012C; // 150 degC
    localparam logic signed [16:0] DPLUS_MAX_CODE   = 17'sh00E10; // 3600 mV
    localparam logic signed [16:0] ZERO_CODE        = 17'sh00000;

endpackage : adc_result_pkg

// >>> sim/adc_result_registers_chk.sv
// Purpose: Port assertions for the result bank.
// Assumes: One clock, sync active-low reset.
// Notes:   High-byte bounds follow the clamped code ranges.
`timescale 1ns/1ps
`default_nettype none
module adc_result_registers_chk (
    input wire logic       sys_clk_in,
    input wire logic       rst_b_in,
    input wire logic [6:0] channel_disable_in,
    input wire logic       rd_en_in,
    input wire logic [7:0] rd_addr_in,
    input wire logic [6:0] conv_request_out,
    input wire logic [7:0] rd_data_out,
    input wire logic       rd_valid_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_b_in);
    req_mask_a: assert property (conv_request_out == ~channel_disable_in)
        else $error("request mask wrong");
    read_answer_a: assert property (rd_en_in |=> rd_valid_out)
        else $error("read not answered");
    valid_pulse_a: assert property (!rd_en_in |=> !rd_valid_out)
        else $error("answer without read");
    data_hold_a: assert property (!rd_en_in |=> $stable(rd_data_out))
        else $error("read byte moved");
    input_range_a: assert property (rd_en_in && rd_addr_in inside {8'h37, 8'h39} |=> rd_data_out <= 8'h75)
        else $error("input result high");
    battery_range_a: assert property (rd_en_in && rd_addr_in == 8'h3B |=> rd_data_out <= 8'h4E)
        else $error("battery result high");
    system_range_a: assert property (rd_en_in && rd_addr_in == 8'h3D |=> rd_data_out <= 8'h5D)
        else $error("system result high");
    therm_range_a: assert property (rd_en_in && rd_addr_in == 8'h3F |=> rd_data_out <= 8'h03)
        else $error("ratio result high");
    die_range_a: assert property (rd_en_in && rd_addr_in == 8'h41 |=> rd_data_out inside {8'h00, 8'h01, 8'hFF})
        else $error("die result out of range");
    dplus_range_a: assert property (rd_en_in && rd_addr_in == 8'h43 |=> rd_data_out <= 8'h0E)
        else $error("dplus result high");
    cover property (rd_en_in && rd_addr_in == 8'h3E);
    cover property (rd_en_in && rd_addr_in == 8'h45);
    cover property (rd_en_in && rd_addr_in == 8'h36);
    cover property (conv_request_out != 7'h7F);
endmodule : adc_result_registers_chk
`default_nettype wire

// >>> sim/adc_result_registers_tb.sv
// Purpose: Random and corner tests of the result bank.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes:   Expected words come from clamp().
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_mismatch++; $display("wrong value at %0t: %h not %h", $time, a, b); end end
module adc_result_registers_tb;
    import adc_result_pkg::*;
    logic        sys_clk_in = 1'b0, rst_b_in = 1'b0, conv_valid_in = 1'b0, rd_en_in = 1'b0;
    logic [2:0]  conv_channel_in = 3'h0;
    logic [15:0] conv_code_in = 16'h0000, pos = 16'h0000, neg = 16'h0000, exp_r [7];
    logic [6:0]  channel_disable_in = 7'h00, conv_request_out;
    logic [7:0]  rd_addr_in = 8'h00, rd_data_out, h, q;
    logic        rd_valid_out;
    logic [31:0] seed = 32'h000104D2;
    int          n_mismatch = 0, samples_checked = 0;
    always #50 sys_clk_in = ~sys_clk_in;
    adc_result_registers adc_result_registers_inst (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
        .conv_valid_in(conv_valid_in), .conv_channel_in(conv_channel_in), .conv_code_in(conv_code_in),
        .battery_sense_positive_in(pos), .battery_sense_negative_in(neg),
        .channel_disable_in(channel_disable_in), .rd_en_in(rd_en_in), .rd_addr_in(rd_addr_in),
        .conv_request_out(conv_request_out), .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out));
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    function automatic logic [15:0] clamp(input logic [2:0] ch, input int v);
        int lim [7] = '{30000, 30000, 20000, 24000, 1023, 300, 3600};
        int lo;
        lo = (ch == CH_DIE) ? -80 : 0;
        if (v < lo) v = lo;
        if (v > lim[ch]) v = lim[ch];
        return v[15:0];
    endfunction : clamp
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk_in) #1;
        rd_en_in = 1'b1;
        rd_addr_in = a;
        @(posedge sys_clk_in) #1;
        rd_en_in = 1'b0;
        `CHK(rd_valid_out, 1'b1)
        d = rd_data_out;
    endtask : rd
    task automatic conv(input logic [2:0] ch, input logic [31:0] r);
        @(posedge sys_clk_in) #1;
        conv_valid_in = 1'b1;
        conv_channel_in = ch;
        conv_code_in = r[15:0] >> r[18:16];
        pos = r[31:16] >> 1;
        neg = {8'h00, r[15:8]};
        channel_disable_in = r[26:20] & r[31:25];
        // Disabled channels and channel 7 keep the old word
        if (ch != 3'h7 && !channel_disable_in[ch]) exp_r[ch] = clamp(ch, ch == CH_BATTERY ?
            int'($signed(pos)) - int'($signed(neg)) : (ch == CH_THERM || ch == CH_DPLUS) ?
            int'(conv_code_in) : int'($signed(conv_code_in)));
        @(posedge sys_clk_in) #1;
        conv_valid_in = 1'b0;
        `CHK(conv_request_out, ~channel_disable_in)
    endtask : conv
    task automatic rdw(input logic [2:0] ch);
        logic [7:0] l;
        rd(8'h37 + {4'h0, ch, 1'b0}, h);
        rd(8'h38 + {4'h0, ch, 1'b0}, l);
        `CHK({h, l}, exp_r[ch])
    endtask : rdw
    task automatic stop_test();
        $display("checked %0d, mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : stop_test
    initial begin
        #2_000_000;
        n_mismatch++;
        stop_test();
    end
    initial begin
        foreach (exp_r[i]) exp_r[i] = RESULT_RESET;
        repeat (4) @(posedge sys_clk_in);
        #1 rst_b_in = 1'b1;
        for (int c = 0; c < 7; c++) rdw(c[2:0]);
        rd(8'h45, h);
        `CHK(h, 8'h00)
        $display("test reset_and_unmapped done");
        foreach (exp_r[i]) conv(3'(i), 32'h0000FFAF + 32'(i) * 32'h00003B01);
        conv(CH_DIE, 32'h0000FFB0);
        conv(CH_BATTERY, 32'h00001000);
        for (int c = 0; c < 7; c++) rdw(c[2:0]);
        $display("test corners done");
        repeat (200) begin
            conv(3'(xs()), xs());
            rdw(3'(xs() % 7));
        end
        $display("test random done");
        conv(CH_SYSTEM, 32'h000012AB);
        rd(SYSTEM_VOLTAGE_RESULT_ADDR, h);
        conv(CH_SYSTEM, 32'h00001388);
        rd(SYSTEM_VOLTAGE_RESULT_ADDR + 8'h01, q);
        `CHK({h, q}, 16'h12AB)
        rdw(CH_SYSTEM);
        $display("test freeze done");
        conv(CH_SYSTEM, 32'h00000ABC);
        rd(SYSTEM_VOLTAGE_RESULT_ADDR, h);
        rd(8'h36, q);
        `CHK(q, UNMAPPED_READ)
        conv(CH_SYSTEM, 32'h00000DEF);
        rd(SYSTEM_VOLTAGE_RESULT_ADDR + 8'h01, q);
        `CHK(q, exp_r[CH_SYSTEM][7:0])
        rst_b_in = 1'b0;
        repeat (2) @(posedge sys_clk_in);
        #1 rst_b_in = 1'b1;
        foreach (exp_r[i]) exp_r[i] = RESULT_RESET;
        for (int c = 0; c < 7; c++) rdw(c[2:0]);
        $display("test pairing_and_reset done");
        stop_test();
    end
endmodule : adc_result_registers_tb
bind adc_result_registers adc_result_registers_chk adc_result_registers_chk_inst (
    .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .channel_disable_in(channel_disable_in),
    .rd_en_in(rd_en_in), .rd_addr_in(rd_addr_in), .conv_request_out(conv_request_out),
    .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out));
`default_nettype wire
